// file: src/restart_defines.svh
// constants for the host-commanded restart sequencer
`ifndef RESTART_DEFINES_SVH
`define RESTART_DEFINES_SVH

// ==========================================================================
// register map
`define RESTART_CTRL_ADDR 8'ha2
`define RESTART_REQ_BIT 7
`define RESTART_WAIT_BIT 6
`define RESTART_SEL_LSB 0
`define RESTART_SEL_MSB 2
`define RESTART_SEL_RESET 3'h0

// ==========================================================================
// timing: shortest delay 512 ms, each step doubles, longest 65.5 s
`define RESTART_CLK_HZ 50000000
`define RESTART_BASE_MS 512
`define RESTART_TICK_HZ 1000
`define RESTART_TICK_DIV (`RESTART_CLK_HZ / `RESTART_TICK_HZ)
`define RESTART_CNT_W 17
`define RESTART_DIV_W 16

`endif

// file: src/restart_pkg.sv
// types shared by the restart sequencer modules
package restart_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_LOAD = 2'b10
  } restart_state_e;
endpackage

// file: src/restart_tick.sv
// millisecond enable divider for the restart delay timer
`timescale 1ns/100ps
`include "restart_defines.svh"

module restart_tick #(
  parameter int TICK_DIV = `RESTART_TICK_DIV // clock cycles per tick
) (
  input wire logic ref_clk, // system clock, 50 MHz
  input wire logic reset_n, // synchronous reset, active low
  input wire logic run, // count while high, clear while low
  output logic tick // one-cycle pulse every millisecond
);
  logic [`RESTART_DIV_W-1:0] div_r;
  logic [`RESTART_DIV_W-1:0] div_nxt;

  // ==========================================================================
  // divider: restarts from zero so the first tick is a full period away
  always_comb begin
    div_nxt = div_r;
    if (!run || tick) begin
      div_nxt = '0;
    end else begin
      div_nxt = div_r + `RESTART_DIV_W'(1);
    end
  end

  assign tick = run && (div_r == `RESTART_DIV_W'(TICK_DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end
endmodule // restart_tick

// file: src/restart_seq.sv
// host-commanded restart sequencer: power off, delay, nonvolatile reload
// Contract
// [RULE_01] Setting the request bit turns the power path off and runs a restart that ends only after the delay.
// [RULE_02] A three-bit field picks the delay from 512 ms up to 65.5 s.
// [RULE_03] The wait flag reads 1 for the whole delay.
// [RULE_04] The wait flag clears by itself when the delay has elapsed.
// [RULE_05] Each restart reloads the volatile registers from nonvolatile memory as at power-up.
// [RULE_06] The request bit does not self-clear and survives the reload.
// [RULE_07] The host writes the request bit to 0 before setting it again.
// [RULE_08] Only a 0 to 1 change of the request bit starts a sequence.
`timescale 1ns/100ps
`include "restart_defines.svh"

module restart_seq #(
  parameter int TICK_DIV = `RESTART_TICK_DIV // clock cycles per delay tick
) (
  input wire logic ref_clk, // system clock, 50 MHz
  input wire logic reset_n, // synchronous reset, active low
  input wire logic wr_en, // register write strobe from the serial slave
  input wire logic [7:0] wr_addr, // register address of the write
  input wire logic [7:0] wr_data, // write data
  input wire logic [7:0] rd_addr, // register address of the read
  output logic [7:0] rd_data, // read data, registered
  output logic power_on, // power path enable, high to conduct
  output logic reload_req, // one-cycle pulse: reload from nonvolatile
  input wire logic reload_done, // nonvolatile loader finished
  input wire logic [2:0] nv_delay_sel, // delay field from nonvolatile image
  output logic restart_reset // high while the device restarts
);
  import restart_pkg::*;

  restart_state_e state_r, state_nxt;
  logic req_r, req_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic [`RESTART_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [7:0] rd_r, rd_nxt;
  logic ctrl_wr;
  logic start;
  logic tick;
  logic done_sync1_r, done_sync2_r;
  logic done_prev_r;
  logic done_rise;

  // delay in ms for a selection: 512 shifted left by the code
  function automatic logic [`RESTART_CNT_W-1:0] delay_ms(
    input logic [2:0] sel);
    delay_ms = `RESTART_CNT_W'(`RESTART_BASE_MS) << sel;
  endfunction

  // ==========================================================================
  // millisecond enable, running only during the delay
  restart_tick #(.TICK_DIV(TICK_DIV)) u_tick (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(state_r == ST_WAIT),
    .tick(tick)
  );

  // ==========================================================================
  // loader done comes from the nonvolatile block's own timing, so resync it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      done_sync1_r <= 1'b0;
      done_sync2_r <= 1'b0;
      done_prev_r <= 1'b0;
    end else begin
      done_sync1_r <= reload_done;
      done_sync2_r <= done_sync1_r;
      done_prev_r <= done_sync2_r;
    end
  end

  // ==========================================================================
  // loader done edge: a level left high by the last reload must not end
  // the next one at once, so only a fresh rise counts
  assign done_rise = done_sync2_r && !done_prev_r;

  assign ctrl_wr = wr_en && (wr_addr == `RESTART_CTRL_ADDR);
  // a write of 1 over a held 1 starts nothing; host must clear first
  assign start = ctrl_wr && wr_data[`RESTART_REQ_BIT] && !req_r; // RULE_08 RULE_07

  // ==========================================================================
  // register and sequencer next state
  always_comb begin
    state_nxt = state_r;
    req_nxt = req_r;
    sel_nxt = sel_r;
    cnt_nxt = cnt_r;
    if (ctrl_wr) begin
      req_nxt = wr_data[`RESTART_REQ_BIT];
      sel_nxt = wr_data[`RESTART_SEL_MSB:`RESTART_SEL_LSB]; // RULE_02
    end
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = ST_WAIT; // RULE_01
          cnt_nxt = delay_ms(sel_nxt); // RULE_02
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (cnt_r == `RESTART_CNT_W'(1)) begin
            state_nxt = ST_LOAD; // RULE_04
          end
          cnt_nxt = cnt_r - `RESTART_CNT_W'(1);
        end
      end
      ST_LOAD: begin
        // request bit left as is: the reload does not touch it
        sel_nxt = nv_delay_sel; // RULE_05 RULE_06
        if (done_rise) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // read mux: wait flag tracks the delay state directly
  always_comb begin
    rd_nxt = 8'h00;
    if (rd_addr == `RESTART_CTRL_ADDR) begin
      rd_nxt[`RESTART_REQ_BIT] = req_r; // RULE_06
      rd_nxt[`RESTART_WAIT_BIT] = (state_r == ST_WAIT); // RULE_03
      rd_nxt[`RESTART_SEL_MSB:`RESTART_SEL_LSB] = sel_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      req_r <= 1'b0;
      sel_r <= `RESTART_SEL_RESET;
      cnt_r <= '0;
      rd_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      req_r <= req_nxt;
      sel_r <= sel_nxt;
      cnt_r <= cnt_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign rd_data = rd_r;
  assign power_on = (state_r == ST_IDLE); // RULE_01
  assign restart_reset = (state_r != ST_IDLE);
  assign reload_req = (state_r == ST_WAIT) && (state_nxt == ST_LOAD); // RULE_05

  // ==========================================================================
  // checks
  a_start_powers_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_IDLE && start) |=> (!power_on && rd_nxt[6] == (rd_addr == 8'ha2))) // RULE_01
    else $error("restart did not cut power");
  a_wait_flag_on: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rd_addr == 8'ha2 && state_r == ST_WAIT) |=> rd_data[6]) // RULE_03
    else $error("wait flag low during delay");
  a_delay_loaded: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_IDLE && start) |=> cnt_r == (17'd512 << $past(sel_nxt))) // RULE_02
    else $error("wrong delay loaded");
  a_wait_ends: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_WAIT && tick && cnt_r == 17'd1) |-> reload_req ##1 (state_r == ST_LOAD)) // RULE_04
    else $error("delay end not taken");
  a_no_early_end: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_r == ST_WAIT && cnt_r > 17'd1) |=> state_r == ST_WAIT) // RULE_04
    else $error("delay left early");
  a_reload_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
    reload_req |=> !reload_req && state_r == ST_LOAD) // RULE_05
    else $error("reload pulse wrong");
  a_req_kept: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!ctrl_wr && req_r) |=> req_r) // RULE_06
    else $error("request bit self-cleared");
  a_rewrite_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (ctrl_wr && req_r && state_r == ST_IDLE) |=> state_r == ST_IDLE) // RULE_08
    else $error("held request restarted");

  // ==========================================================================
  // checks: power path, flags and reload

  // power conducts exactly while no sequence runs
  a_idle_power_on: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_01
    (state_r == ST_IDLE) |-> (power_on && !restart_reset))
    else $error("power off while idle");

  // power stays cut through delay and reload
  a_busy_power_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_01
    (state_r != ST_IDLE) |-> (!power_on && restart_reset))
    else $error("power on during restart");

  // wait flag reads 0 once the delay is over
  a_flag_clears: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_04
    (state_r == ST_LOAD && rd_addr == `RESTART_CTRL_ADDR)
    |=> !rd_data[`RESTART_WAIT_BIT])
    else $error("wait flag set after delay");

  // the reload takes the delay field from the image
  a_reload_nv_sel: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_05
    (state_r == ST_LOAD) |=> (sel_r == $past(nv_delay_sel)))
    else $error("delay field not reloaded");

  // reload must not touch the request bit
  a_req_survives: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_06
    (state_r == ST_LOAD && !ctrl_wr) |=> (req_r == $past(req_r)))
    else $error("reload changed request bit");

  // every control write stores the request bit as written
  a_req_written: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_08
    ctrl_wr |=> (req_r == $past(wr_data[`RESTART_REQ_BIT])))
    else $error("request bit not stored");

  // the delay timer only advances during the wait
  a_tick_in_wait: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_02
    tick |-> (state_r == ST_WAIT))
    else $error("tick outside the wait");

  // reload holds until the loader reports a fresh finish
  a_load_waits_done: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_05
    (state_r == ST_LOAD && !done_rise) |=> (state_r == ST_LOAD))
    else $error("reload ended early");

  // nothing but a start leaves idle
  a_idle_needs_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // RULE_08
    (state_r == ST_IDLE && !start) |=> (state_r == ST_IDLE))
    else $error("sequence began without start");
endmodule // restart_seq

// file: test/restart_nv_model.sv
// nonvolatile loader stand-in for the restart sequencer bench
`timescale 1ns/100ps
module restart_nv_model #(
  parameter int LAT = 4 // copy latency in cycles, raise it for a slow loader
) (
  input wire logic ref_clk, // system clock
  input wire logic reload_req, // reload pulse from the sequencer
  output logic reload_done, // high once the image is copied
  output logic [2:0] nv_delay_sel // delay field held in the image
);
  int cnt = 0;
  initial reload_done = 1'b0;
  // shortest delay in the image keeps any rerun cheap
  assign nv_delay_sel = 3'h0;
  // done drops on a new request and rises when the latency runs out
  always @(posedge ref_clk) begin
    if (reload_req) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
    reload_done <= reload_req ? 1'b0 : (reload_done | (cnt == 1));
  end
endmodule // restart_nv_model

// file: test/host_commanded_reboot_test.sv
// self-checking bench for the restart sequencer
`timescale 1ns/100ps
module host_commanded_reboot_test;
  logic ref_clk = 1'b0, reset_n = 1'b0, wr_en = 1'b0;
  logic reload_req, reload_done, power_on, restart_reset;
  logic [7:0] wr_addr = 8'ha2, wr_data = 8'h00, rd_addr = 8'ha2, rd_data;
  logic [2:0] nv_delay_sel;
  int fails = 0, n_compared = 0, n = 0;
  // short tick so a whole delay fits in the run
  localparam int BENCH_DIV = 2;
  // rows: written byte, byte read back (bits 6:3 never stick)
  logic [7:0] wrow [4] = '{8'h01, 8'h7a, 8'h07, 8'h04};
  logic [7:0] erow [4] = '{8'h01, 8'h02, 8'h07, 8'h04};

  restart_seq #(.TICK_DIV(BENCH_DIV)) i_restart_seq (.ref_clk(ref_clk),
    .reset_n(reset_n),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data), .power_on(power_on), .reload_req(reload_req),
    .reload_done(reload_done), .nv_delay_sel(nv_delay_sel),
    .restart_reset(restart_reset));
  restart_nv_model i_restart_nv_model (.ref_clk(ref_clk),
    .reload_req(reload_req), .reload_done(reload_done),
    .nv_delay_sel(nv_delay_sel));

  always #10 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one write strobe; entered just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_addr = a;
    wr_data = d;
    wr_en = 1'b1;
    @(posedge ref_clk) #1 wr_en = 1'b0;
  endtask
  // read data is registered, so look one edge later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_addr = a;
    @(posedge ref_clk) #1 chk(rd_data, e);
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    rd(8'ha2, 8'h00);
    chk({6'h0, power_on, restart_reset}, 8'h02);
    rd(8'ha3, 8'h00); // unmapped place reads zero
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(8'ha2, wrow[i]);
      rd(8'ha2, erow[i]);
    end
    $display("table test done");
    wr(8'ha2, 8'h83);
    chk({6'h0, power_on, restart_reset}, 8'h01);
    rd(8'ha2, 8'hc3);
    repeat (2000) @(posedge ref_clk);
    rd(8'ha2, 8'hc3);
    wr(8'ha2, 8'h81);
    rd(8'ha2, 8'hc1);
    wr(8'ha2, 8'h01);
    wr(8'ha2, 8'h85);
    rd(8'ha2, 8'hc5);
    chk({7'h0, power_on}, 8'h00);
    $display("restart test done");
    reset_n = 1'b0;
    @(posedge ref_clk) #1 reset_n = 1'b1;
    rd(8'ha2, 8'h00);
    chk({6'h0, power_on, restart_reset}, 8'h02);
    $display("second reset test done");
    wr(8'ha2, 8'h80);
    while (!reload_req && n < 3000) begin
      @(posedge ref_clk) #1 n++;
    end
    chk(n, 512 * BENCH_DIV - 1);
    @(posedge ref_clk) #1;
    rd(8'ha2, 8'h80);
    chk({7'h0, power_on}, 8'h00);
    n = 0;
    while (!power_on && n < 100) begin
      @(posedge ref_clk) #1 n++;
    end
    chk({6'h0, power_on, restart_reset}, 8'h02);
    rd(8'ha2, 8'h80);
    wr(8'ha2, 8'h80);
    chk({7'h0, power_on}, 8'h01);
    wr(8'ha2, 8'h00);
    wr(8'ha2, 8'h80);
    chk({7'h0, power_on}, 8'h00);
    n = 0;
    while (!power_on && n < 3000) begin
      @(posedge ref_clk) #1 n++;
    end
    // delay, loader latency of 4, two sync stages and the edge stage
    chk(n, 512 * BENCH_DIV + 7);
    $display("reload test done");
    conclude();
  end
endmodule // host_commanded_reboot_test
